// ===== logic/egf_defines.svh
// Constants of the electronic gearing follower: offsets, fields, timing.
`ifndef EGF_DEFINES_SVH
`define EGF_DEFINES_SVH

`define EGF_CLK_HZ          20000000
`define EGF_UPDATE_US       1
`define EGF_UPDATE_CYCLES   ((`EGF_CLK_HZ / 1000000) * `EGF_UPDATE_US)
`define EGF_DIV_W           5

`define EGF_PCT_UNITY       16'h0064
`define EGF_PCT_RESET       16'h0064
`define EGF_ACC_W           18

`define EGF_OFF_CTRL        8'h00
`define EGF_OFF_SCALE_PCT   8'h04
`define EGF_OFF_RATIO       8'h08
`define EGF_OFF_NUM         8'h0c
`define EGF_OFF_DEN         8'h10
`define EGF_OFF_DECIMALS    8'h14
`define EGF_OFF_ACCEL       8'h18
`define EGF_OFF_DECEL       8'h1c
`define EGF_OFF_TRACK_MAX   8'h20
`define EGF_OFF_STATUS      8'h24
`define EGF_OFF_TRACK_ERR   8'h28
`define EGF_OFF_LOST        8'h2c
`define EGF_OFF_CMD_POS     8'h30
`define EGF_OFF_CMD         8'h34

`define EGF_CTRL_RAMP_UP    0
`define EGF_CTRL_RAMP_DOWN  1
`define EGF_CTRL_FRACTION   2
`define EGF_CTRL_TRACK_EN   3
`define EGF_CTRL_DIR_LO     4
`define EGF_CTRL_DIR_HI     5
`define EGF_CMD_START       0
`define EGF_CMD_STOP        1

`define EGF_RATIO_RESET     32'h00000001
`define EGF_NUM_RESET       32'h00000001
`define EGF_DEN_RESET       32'h00000001
`define EGF_TRACK_MAX_RESET 32'h00001000

`endif

// ===== logic/egf_pkg.sv
// Types of the electronic gearing follower.
package egf_pkg;

    typedef enum logic [3:0] {
        EGF_IDLE   = 4'h1,
        EGF_ACCEL  = 4'h2,
        EGF_LOCKED = 4'h4,
        EGF_DECEL  = 4'h8
    } egf_fsm_t;

    typedef enum logic [1:0] {
        EGF_DIR_BOTH = 2'h0,
        EGF_DIR_NEG  = 2'h1,
        EGF_DIR_POS  = 2'h2
    } egf_dir_t;

    typedef struct packed {
        logic        followActive;
        logic        followLocked;
        logic        followDone;
        logic        followAccelerating;
        logic        followDecelerating;
        logic        trackingFault;
    } egf_flags_t;

    typedef struct packed {
        logic        rampUpEn;
        logic        rampDownEn;
        logic        fractionModeEn;
        logic        trackingCheckEn;
        egf_dir_t    dir;
        logic [15:0] scalePct;
        logic [31:0] ratio;
        logic [31:0] scaleNum;
        logic [31:0] scaleDen;
        logic [2:0]  decimals;
        logic [31:0] accel;
        logic [31:0] decel;
        logic [31:0] trackMax;
    } egf_cfg_t;

    typedef struct packed {
        egf_cfg_t    cfg;
        egf_fsm_t    fsm;
        logic        ownerProg;
        logic        actSync1;
        logic        actSync2;
        logic        actPrev;
        logic        bypSync1;
        logic        bypSync2;
        logic [4:0]  divCnt;
        logic [17:0] timeAcc;
        logic [31:0] masterPrev;
        logic [31:0] rem;
        logic [31:0] vel;
        logic [31:0] cmdPos;
        logic [31:0] trackErr;
        logic [31:0] lost;
        egf_flags_t  flags;
        logic [31:0] rdata;
    } egf_regs_t;

endpackage : egf_pkg

// ===== logic/egf_follower.sv
// Electronic gearing follower with time scaling and tracking-error check.
//
// Added by the designer: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
`include "egf_defines.svh"

module egf_follower (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        we,
    input  wire logic        re,
    output logic      [31:0] rdata,
    input  wire logic        gearActivateIn,
    input  wire logic        timeScaleBypassIn,
    input  wire logic [31:0] masterPos,
    input  wire logic [31:0] feedbackPos,
    output logic      [31:0] followCmdPos,
    output logic             followActive,
    output logic             followLocked,
    output logic             followDone,
    output logic             followAccelerating,
    output logic             followDecelerating,
    output logic             trackingFault
);

    localparam logic [4:0] UPD_LAST = 5'(`EGF_UPDATE_CYCLES - 1);

    egf_pkg::egf_regs_t st_reg;
    egf_pkg::egf_regs_t st_next;

    logic              baseTick;
    logic              motionTick;
    logic [17:0]       accSum;
    logic [15:0]       effPct;
    logic signed [31:0] masterDelta;
    logic signed [31:0] dmFilt;
    logic signed [31:0] mulNum;
    logic signed [31:0] mulDen;
    logic signed [63:0] prod;
    logic signed [63:0] quot;
    logic signed [31:0] target;
    logic signed [31:0] velStep;
    logic signed [32:0] errWide;
    logic [32:0]        errAbs;
    logic              levelStart;
    logic              progStart;
    logic              progStop;
    logic              levelStop;

    function automatic logic signed [31:0] pow10(input logic [2:0] d);
        case (d)
            3'h0:    pow10 = 32'sh00000001;
            3'h1:    pow10 = 32'sh0000000a;
            3'h2:    pow10 = 32'sh00000064;
            3'h3:    pow10 = 32'sh000003e8;
            3'h4:    pow10 = 32'sh00002710;
            3'h5:    pow10 = 32'sh000186a0;
            3'h6:    pow10 = 32'sh000f4240;
            default: pow10 = 32'sh00989680;
        endcase
    endfunction : pow10

    function automatic logic signed [31:0] stepToward(
        input logic signed [31:0] v,
        input logic signed [31:0] t,
        input logic        [31:0] a);
        logic signed [33:0] s;
        s = 34'sd0;
        if (v < t) begin
            s = 34'(v) + $signed({2'h0, a});
            stepToward = (s > 34'(t)) ? t : 32'(s);
        end else begin
            s = 34'(v) - $signed({2'h0, a});
            stepToward = (s < 34'(t)) ? t : 32'(s);
        end
    endfunction : stepToward

    always_comb begin
        st_next = st_reg;
        st_next.actSync1 = gearActivateIn;
        st_next.actSync2 = st_reg.actSync1;
        st_next.actPrev  = st_reg.actSync2;
        st_next.bypSync1 = timeScaleBypassIn;
        st_next.bypSync2 = st_reg.bypSync1;

        // Base update tick, then scaled motion ticks from a rate accumulator.
        baseTick = (st_reg.divCnt == UPD_LAST);
        st_next.divCnt = baseTick ? 5'h0 : st_reg.divCnt + 5'h1;
        effPct = st_reg.bypSync2 ? `EGF_PCT_UNITY
                                 : st_reg.cfg.scalePct;
        accSum = st_reg.timeAcc + (baseTick ? {2'h0, effPct} : 18'h0);
        motionTick = (accSum >= {2'h0, `EGF_PCT_UNITY});
        st_next.timeAcc = motionTick ? accSum - {2'h0, `EGF_PCT_UNITY}
                                     : accSum;

        // Master increment, direction filter and ratio arithmetic.
        masterDelta = $signed(masterPos - st_reg.masterPrev);
        case (st_reg.cfg.dir)
            egf_pkg::EGF_DIR_NEG: dmFilt = masterDelta[31] ? masterDelta : '0;
            egf_pkg::EGF_DIR_POS: dmFilt = masterDelta[31] ? '0 : masterDelta;
            default:              dmFilt = masterDelta;
        endcase
        if (st_reg.cfg.fractionModeEn) begin
            mulNum = $signed(st_reg.cfg.scaleNum);
            mulDen = (st_reg.cfg.scaleDen == 32'h0) ? 32'sh1
                                                    : $signed(st_reg.cfg.scaleDen);
        end else begin
            mulNum = $signed(st_reg.cfg.ratio);
            mulDen = pow10(st_reg.cfg.decimals);
        end
        prod = 64'(dmFilt) * 64'(mulNum) + 64'($signed(st_reg.rem));
        quot = prod / 64'(mulDen);
        target = 32'(quot);

        levelStart = st_reg.actSync2 && !st_reg.actPrev;
        progStart  = we && (addr == `EGF_OFF_CMD) && wdata[`EGF_CMD_START];
        progStop   = we && (addr == `EGF_OFF_CMD) && wdata[`EGF_CMD_STOP];
        levelStop  = !st_reg.ownerProg && !st_reg.actSync2;
        velStep = st_reg.vel;

        if (motionTick) begin
            st_next.masterPrev = masterPos;
            st_next.rem = (st_reg.fsm == egf_pkg::EGF_IDLE) ? 32'h0
                        : 32'(prod - quot * 64'(mulDen));
        end

        case (st_reg.fsm)
            egf_pkg::EGF_IDLE: begin
                velStep = '0;
                if (levelStart || progStart) begin
                    st_next.ownerProg = !levelStart;
                    st_next.lost = 32'h0;
                    st_next.flags.followDone = 1'b0;
                    st_next.fsm = st_reg.cfg.rampUpEn ? egf_pkg::EGF_ACCEL
                                                      : egf_pkg::EGF_LOCKED;
                end
            end
            egf_pkg::EGF_ACCEL, egf_pkg::EGF_LOCKED: begin
                if (motionTick) begin
                    if (st_reg.fsm == egf_pkg::EGF_ACCEL) begin
                        velStep = stepToward($signed(st_reg.vel), target,
                                             st_reg.cfg.accel);
                        st_next.lost = st_reg.lost
                                     + 32'(target - velStep);
                        if (velStep == target) begin
                            st_next.fsm = egf_pkg::EGF_LOCKED;
                        end
                    end else begin
                        velStep = target;
                    end
                end
                if (levelStop) begin
                    velStep = '0;
                    st_next.fsm = egf_pkg::EGF_IDLE;
                    st_next.flags.followDone = 1'b1;
                end else if (progStop && st_reg.ownerProg) begin
                    if (st_reg.cfg.rampDownEn) begin
                        st_next.fsm = egf_pkg::EGF_DECEL;
                    end else begin
                        velStep = '0;
                        st_next.fsm = egf_pkg::EGF_IDLE;
                        st_next.flags.followDone = 1'b1;
                    end
                end
            end
            egf_pkg::EGF_DECEL: begin
                if (motionTick) begin
                    velStep = stepToward($signed(st_reg.vel), 32'sh0,
                                         st_reg.cfg.decel);
                    if (velStep == 32'sh0) begin
                        st_next.fsm = egf_pkg::EGF_IDLE;
                        st_next.flags.followDone = 1'b1;
                    end
                end
            end
            default: begin
                velStep = '0;
                st_next.fsm = egf_pkg::EGF_IDLE;
            end
        endcase
        st_next.vel = velStep;
        if (motionTick) begin
            st_next.cmdPos = st_reg.cmdPos + velStep;
        end

        st_next.flags.followActive =
            (st_next.fsm != egf_pkg::EGF_IDLE);
        st_next.flags.followLocked =
            (st_next.fsm == egf_pkg::EGF_LOCKED);
        st_next.flags.followAccelerating =
            (st_next.fsm == egf_pkg::EGF_ACCEL);
        st_next.flags.followDecelerating =
            (st_next.fsm == egf_pkg::EGF_DECEL);

        // Tracking error and fault.
        errWide = 33'($signed(st_reg.cmdPos)) - 33'($signed(feedbackPos));
        st_next.trackErr = 32'(errWide);
        errAbs = errWide[32] ? 33'(-errWide) : 33'(errWide);
        st_next.flags.trackingFault = st_reg.cfg.trackingCheckEn
            && (errAbs > {1'b0, st_reg.cfg.trackMax});

        // Register writes.
        if (we) begin
            case (addr)
                `EGF_OFF_CTRL: begin
                    st_next.cfg.rampUpEn       = wdata[`EGF_CTRL_RAMP_UP];
                    st_next.cfg.rampDownEn     = wdata[`EGF_CTRL_RAMP_DOWN];
                    st_next.cfg.fractionModeEn = wdata[`EGF_CTRL_FRACTION];
                    st_next.cfg.trackingCheckEn = wdata[`EGF_CTRL_TRACK_EN];
                    st_next.cfg.dir = egf_pkg::egf_dir_t'(
                        wdata[`EGF_CTRL_DIR_HI:`EGF_CTRL_DIR_LO]);
                end
                `EGF_OFF_SCALE_PCT: st_next.cfg.scalePct = wdata[15:0];
                `EGF_OFF_RATIO:     st_next.cfg.ratio    = wdata;
                `EGF_OFF_NUM:       st_next.cfg.scaleNum = wdata;
                `EGF_OFF_DEN:       st_next.cfg.scaleDen = wdata;
                `EGF_OFF_DECIMALS:  st_next.cfg.decimals = wdata[2:0];
                `EGF_OFF_ACCEL:     st_next.cfg.accel    = wdata;
                `EGF_OFF_DECEL:     st_next.cfg.decel    = wdata;
                `EGF_OFF_TRACK_MAX: st_next.cfg.trackMax = wdata;
                default: begin
                end
            endcase
        end

        // Register reads; data valid only in the cycle after the strobe.
        st_next.rdata = 32'h0;
        if (re) begin
            case (addr)
                `EGF_OFF_CTRL: st_next.rdata = {26'h0, st_reg.cfg.dir,
                    st_reg.cfg.trackingCheckEn, st_reg.cfg.fractionModeEn,
                    st_reg.cfg.rampDownEn, st_reg.cfg.rampUpEn};
                `EGF_OFF_SCALE_PCT: st_next.rdata = {16'h0, st_reg.cfg.scalePct};
                `EGF_OFF_RATIO:     st_next.rdata = st_reg.cfg.ratio;
                `EGF_OFF_NUM:       st_next.rdata = st_reg.cfg.scaleNum;
                `EGF_OFF_DEN:       st_next.rdata = st_reg.cfg.scaleDen;
                `EGF_OFF_DECIMALS:  st_next.rdata = {29'h0, st_reg.cfg.decimals};
                `EGF_OFF_ACCEL:     st_next.rdata = st_reg.cfg.accel;
                `EGF_OFF_DECEL:     st_next.rdata = st_reg.cfg.decel;
                `EGF_OFF_TRACK_MAX: st_next.rdata = st_reg.cfg.trackMax;
                `EGF_OFF_STATUS:    st_next.rdata = {25'h0, st_reg.ownerProg,
                                                     st_reg.flags};
                `EGF_OFF_TRACK_ERR: st_next.rdata = st_reg.trackErr;
                `EGF_OFF_LOST:      st_next.rdata = st_reg.lost;
                `EGF_OFF_CMD_POS:   st_next.rdata = st_reg.cmdPos;
                default:            st_next.rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_reg              <= '0;
            st_reg.fsm          <= egf_pkg::EGF_IDLE;
            st_reg.cfg.scalePct <= `EGF_PCT_RESET;
            st_reg.cfg.ratio    <= `EGF_RATIO_RESET;
            st_reg.cfg.scaleNum <= `EGF_NUM_RESET;
            st_reg.cfg.scaleDen <= `EGF_DEN_RESET;
            st_reg.cfg.trackMax <= `EGF_TRACK_MAX_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    assign rdata              = st_reg.rdata;
    assign followCmdPos       = st_reg.cmdPos;
    assign followActive       = st_reg.flags.followActive;
    assign followLocked       = st_reg.flags.followLocked;
    assign followDone         = st_reg.flags.followDone;
    assign followAccelerating = st_reg.flags.followAccelerating;
    assign followDecelerating = st_reg.flags.followDecelerating;
    assign trackingFault      = st_reg.flags.trackingFault;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    a_accel_not_locked: assert property (
        followAccelerating |-> !followLocked && followActive)
        else $error("accelerating and locked together");

    a_decel_not_done: assert property (
        followDecelerating |-> !followDone && followActive)
        else $error("decelerating while done");

    a_level_release_done: assert property (
        (st_reg.fsm != egf_pkg::EGF_IDLE) && !st_reg.ownerProg
        && !st_reg.actSync2 |=> followDone && !followActive)
        else $error("level release did not stop at once");

    a_prog_stop_owner: assert property (
        (st_reg.fsm == egf_pkg::EGF_LOCKED) && !st_reg.ownerProg
        && st_reg.actSync2 && progStop |=> followLocked)
        else $error("program stop ended level gearing");

    a_start_noramp_lock: assert property (
        (st_reg.fsm == egf_pkg::EGF_IDLE) && levelStart
        && !st_reg.cfg.rampUpEn |=> followLocked && !followDone)
        else $error("start without ramp not locked");

    a_done_holds: assert property (
        followDone && !followActive && !levelStart && !progStart
        |=> followDone)
        else $error("done dropped without a start");

    a_fault_needs_en: assert property (
        trackingFault |-> $past(st_reg.cfg.trackingCheckEn))
        else $error("fault raised while checking disabled");

    a_err_difference: assert property (
        ##1 st_reg.trackErr == $past(st_reg.cmdPos) - $past(feedbackPos))
        else $error("tracking error not command minus feedback");

    a_lost_only_ramp: assert property (
        (st_reg.fsm == egf_pkg::EGF_LOCKED) |=> $stable(st_reg.lost))
        else $error("lost distance changed while locked");

    a_pos_only_tick: assert property (
        !motionTick && (st_reg.fsm != egf_pkg::EGF_IDLE)
        |=> $stable(followCmdPos))
        else $error("position moved without a motion tick");

    a_prog_stop_ends: assert property (
        (st_reg.fsm == egf_pkg::EGF_LOCKED) && st_reg.ownerProg && progStop
        && !st_reg.cfg.rampDownEn |=> followDone && !followActive)
        else $error("program stop did not end program gearing");

    a_bypass_unity: assert property (
        st_reg.bypSync2 && baseTick |-> motionTick)
        else $error("bypass did not run at unity scale");

    a_start_clears_done: assert property (
        (st_reg.fsm == egf_pkg::EGF_IDLE) && progStart
        |=> followActive && !followDone)
        else $error("program start did not begin gearing");

    a_decel_holds: assert property (
        (st_reg.fsm == egf_pkg::EGF_DECEL) && !motionTick
        |=> followDecelerating && $stable(st_reg.vel))
        else $error("ramp down changed between motion ticks");

    a_decel_only_prog: assert property (
        followDecelerating |-> st_reg.ownerProg)
        else $error("level gearing ramped down");

    c_locked: cover property (followAccelerating ##1 followLocked);
    c_decel_done: cover property (followDecelerating ##1 followDone);
    c_fault: cover property (trackingFault);
    c_prog_start: cover property (progStart ##1 st_reg.ownerProg);
    c_level_start: cover property (levelStart ##1 followActive);

endmodule : egf_follower

`default_nettype wire

// ===== verification/egf_axis_model.sv
// Partner model: master axis command and motor position feedback.
`timescale 1ns/10ps
`default_nettype none
module egf_axis_model (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic [31:0] masterRate,
    input  wire logic [31:0] masterAdd,
    input  wire logic [31:0] fbLag,
    input  wire logic [31:0] followCmdPos,
    output logic      [31:0] masterPos,
    output logic      [31:0] feedbackPos
);
    // The master moves by a steady rate plus one-off jumps.
    // The feedback trails the command by a set lag, one cycle late.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            masterPos   <= 32'h0;
            feedbackPos <= 32'h0;
        end else begin
            masterPos   <= masterPos + masterRate + masterAdd;
            feedbackPos <= followCmdPos - fbLag;
        end
    end
endmodule : egf_axis_model
`default_nettype wire

// ===== verification/testbench.sv
// Self-checking testbench of the electronic gearing follower.
`timescale 1ns/10ps
`default_nettype none
`include "egf_defines.svh"
module testbench;
    logic        clk;
    logic        rstn;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        we;
    logic        re;
    logic [31:0] rdata;
    logic        gearIn;
    logic        bypassIn;
    logic [31:0] masterPos;
    logic [31:0] feedbackPos;
    logic [31:0] cmdPos;
    logic [31:0] masterRate;
    logic [31:0] masterAdd;
    logic [31:0] fbLag;
    logic        act;
    logic        lck;
    logic        dn;
    logic        acc;
    logic        dec;
    logic        flt;
    int          mismatches;
    int          comparisons;
    int          n;

    egf_follower u_dut (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata),
        .we(we), .re(re), .rdata(rdata), .gearActivateIn(gearIn),
        .timeScaleBypassIn(bypassIn), .masterPos(masterPos),
        .feedbackPos(feedbackPos), .followCmdPos(cmdPos),
        .followActive(act), .followLocked(lck), .followDone(dn),
        .followAccelerating(acc), .followDecelerating(dec),
        .trackingFault(flt));

    egf_axis_model u_axis (.clk(clk), .rstn(rstn), .masterRate(masterRate),
        .masterAdd(masterAdd), .fbLag(fbLag), .followCmdPos(cmdPos),
        .masterPos(masterPos), .feedbackPos(feedbackPos));

    task automatic end_sim();
        $display("Comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input string nm, input logic [31:0] exp,
                       input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        we    <= 1'b1;
        addr  <= a;
        wdata <= v;
        @(posedge clk);
        we    <= 1'b0;
    endtask : wr

    task automatic rchk(input string nm, input logic [7:0] a,
                        input logic [31:0] exp);
        @(posedge clk);
        re   <= 1'b1;
        addr <= a;
        @(posedge clk);
        re   <= 1'b0;
        #1;
        chk(nm, exp, rdata);
    endtask : rchk

    // Jumps the master once and checks the follower's travel.
    task automatic move(input string nm, input logic [31:0] add,
                        input logic [31:0] exp);
        logic [31:0] p0;
        p0 = cmdPos;
        @(posedge clk);
        masterAdd <= add;
        @(posedge clk);
        masterAdd <= 32'h0;
        repeat (80) @(posedge clk);
        chk(nm, p0 + exp, cmdPos);
    endtask : move

    task automatic t_reset();
        rchk("scale_pct", `EGF_OFF_SCALE_PCT, 32'h00000064);
        rchk("ratio", `EGF_OFF_RATIO, 32'h00000001);
        rchk("num", `EGF_OFF_NUM, 32'h00000001);
        rchk("den", `EGF_OFF_DEN, 32'h00000001);
        rchk("track_max", `EGF_OFF_TRACK_MAX, 32'h00001000);
        rchk("status", `EGF_OFF_STATUS, 32'h00000000);
        rchk("unmapped", 8'h3c, 32'h00000000);
    endtask : t_reset

    task automatic t_gear();
        wr(`EGF_OFF_RATIO, 32'h00000003);
        wr(`EGF_OFF_CMD, 32'h00000001);
        repeat (2) @(posedge clk);
        chk("active", 32'h1, act);
        chk("locked", 32'h1, lck);
        chk("done", 32'h0, dn);
        move("ratio_pos", 32'h00000064, 32'h0000012c);
        wr(`EGF_OFF_SCALE_PCT, 32'h00000000);
        move("scale_zero", 32'h0000000a, 32'h00000000);
        @(posedge clk);
        bypassIn <= 1'b1;
        move("bypass", 32'h00000000, 32'h0000001e);
        @(posedge clk);
        bypassIn <= 1'b0;
        move("scale_back", 32'h0000000a, 32'h00000000);
        wr(`EGF_OFF_SCALE_PCT, 32'h00000064);
        move("scale_now", 32'h00000000, 32'h0000001e);
        wr(`EGF_OFF_RATIO, 32'hfffffffe);
        move("ratio_neg", 32'h00000064, 32'hffffff38);
        wr(`EGF_OFF_RATIO, 32'h00000019);
        wr(`EGF_OFF_DECIMALS, 32'h00000001);
        move("decimals", 32'h00000064, 32'h000000fa);
        wr(`EGF_OFF_RATIO, 32'h00000001);
        wr(`EGF_OFF_DECIMALS, 32'h00000000);
        wr(`EGF_OFF_CTRL, 32'h00000020);
        move("pos_drop", 32'hffffffce, 32'h00000000);
        move("pos_pass", 32'h00000032, 32'h00000032);
        wr(`EGF_OFF_CTRL, 32'h00000010);
        move("neg_drop", 32'h00000032, 32'h00000000);
        move("neg_pass", 32'hffffffce, 32'hffffffce);
        wr(`EGF_OFF_CTRL, 32'h00000004);
        wr(`EGF_OFF_RATIO, 32'h00000007);
        wr(`EGF_OFF_NUM, 32'h00000002);
        wr(`EGF_OFF_DEN, 32'h00000003);
        move("fraction", 32'h00000064, 32'h00000042);
        move("remainder", 32'h00000002, 32'h00000002);
        wr(`EGF_OFF_CMD, 32'h00000002);
        repeat (2) @(posedge clk);
        chk("stop_done", 32'h1, dn);
        chk("stop_active", 32'h0, act);
        chk("stop_locked", 32'h0, lck);
    endtask : t_gear

    task automatic t_paths();
        wr(`EGF_OFF_CTRL, 32'h00000002);
        gearIn <= 1'b1;
        repeat (5) @(posedge clk);
        chk("lvl_active", 32'h1, act);
        wr(`EGF_OFF_CMD, 32'h00000002);
        wr(`EGF_OFF_CMD, 32'h00000001);
        repeat (3) @(posedge clk);
        chk("lvl_keep", 32'h1, act);
        gearIn <= 1'b0;
        repeat (5) @(posedge clk);
        chk("lvl_off", 32'h0, act);
        chk("lvl_no_ramp", 32'h0, dec);
        chk("lvl_done", 32'h1, dn);
        wr(`EGF_OFF_CTRL, 32'h00000000);
        wr(`EGF_OFF_CMD, 32'h00000001);
        gearIn <= 1'b1;
        repeat (5) @(posedge clk);
        gearIn <= 1'b0;
        repeat (5) @(posedge clk);
        chk("prog_owner", 32'h1, act);
        wr(`EGF_OFF_CMD, 32'h00000002);
        repeat (2) @(posedge clk);
        chk("prog_done", 32'h1, dn);
    endtask : t_paths

    task automatic t_ramps();
        @(posedge clk);
        masterRate <= 32'h00000001;
        wr(`EGF_OFF_RATIO, 32'h00000001);
        wr(`EGF_OFF_CTRL, 32'h00000003);
        wr(`EGF_OFF_ACCEL, 32'h00000001);
        wr(`EGF_OFF_DECEL, 32'h00000001);
        repeat (40) @(posedge clk);
        wr(`EGF_OFF_CMD, 32'h00000001);
        repeat (2) @(posedge clk);
        chk("accel_on", 32'h1, acc);
        chk("accel_unlocked", 32'h0, lck);
        for (n = 0; n < 3000 && lck !== 1'b1; n++) @(posedge clk);
        chk("accel_span", 32'h1, n > 300 && n < 500);
        chk("accel_off", 32'h0, acc);
        rchk("lost", `EGF_OFF_LOST, 32'h000000be);
        wr(`EGF_OFF_CMD, 32'h00000002);
        repeat (2) @(posedge clk);
        chk("decel_on", 32'h1, dec);
        chk("decel_notdone", 32'h0, dn);
        for (n = 0; n < 3000 && dn !== 1'b1; n++) @(posedge clk);
        chk("decel_span", 32'h1, n > 300 && n < 500);
        chk("decel_off", 32'h0, dec);
        masterRate <= 32'h00000000;
    endtask : t_ramps

    task automatic t_track();
        wr(`EGF_OFF_CTRL, 32'h00000008);
        wr(`EGF_OFF_TRACK_MAX, 32'h00000005);
        fbLag <= 32'h00000005;
        repeat (5) @(posedge clk);
        chk("fault_at_max", 32'h0, flt);
        rchk("track_err", `EGF_OFF_TRACK_ERR, 32'h00000005);
        fbLag <= 32'h00000006;
        repeat (5) @(posedge clk);
        chk("fault_pos", 32'h1, flt);
        fbLag <= 32'hfffffffa;
        repeat (5) @(posedge clk);
        chk("fault_neg", 32'h1, flt);
        wr(`EGF_OFF_CTRL, 32'h00000000);
        repeat (3) @(posedge clk);
        chk("fault_off", 32'h0, flt);
    endtask : t_track

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        end_sim();
    end

    initial begin
        rstn = 1'b0;
        addr = 8'h00;
        wdata = 32'h0;
        we = 1'b0;
        re = 1'b0;
        gearIn = 1'b0;
        bypassIn = 1'b0;
        masterRate = 32'h0;
        masterAdd = 32'h0;
        fbLag = 32'h0;
        mismatches = 0;
        comparisons = 0;
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        t_reset();
        t_gear();
        t_paths();
        t_ramps();
        t_track();
        end_sim();
    end
endmodule : testbench
`default_nettype wire
